// >>> common/speed_limit_pkg.sv
/*
 * constants for the torque mode speed limiter: register map, field
 * positions, reset values and setting ranges.
 * assumes a 32-bit ahb-lite register bus and word-aligned registers.
 */
package speed_limit_pkg;

  // register byte offsets
  localparam logic [7:0] CFG_OFF       = 8'h00;
  localparam logic [7:0] ROT_LIM_OFF   = 8'h04;
  localparam logic [7:0] LIN_LIM_OFF   = 8'h08;
  localparam logic [7:0] GAIN_OFF      = 8'h0c;
  localparam logic [7:0] MOTOR_OFF     = 8'h10;
  localparam logic [7:0] STATUS_OFF    = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFF  = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFF  = 8'h1c;
  localparam logic [7:0] RESTART_OFF   = 8'h20;

  // configuration field positions
  localparam int SRC_SEL_BIT   = 0;
  localparam int CAP_SEL_BIT   = 1;
  localparam int LINEAR_BIT    = 2;
  localparam int ALLOC_LSB     = 4;
  localparam int ALLOC_W       = 3;

  // interrupt event bits
  localparam int EV_ON_BIT     = 0;
  localparam int EV_OFF_BIT    = 1;

  // reset values and ranges
  localparam logic [15:0] INT_LIM_RST  = 16'h2710;
  localparam logic [15:0] INT_LIM_MAX  = 16'h2710;
  localparam logic [15:0] GAIN_RST     = 16'h0258;
  localparam logic [15:0] GAIN_MIN     = 16'h0096;
  localparam logic [15:0] GAIN_MAX     = 16'h0bb8;
  localparam logic [15:0] MAX_SPD_RST  = 16'h1770;
  localparam logic [15:0] OVS_SPD_RST  = 16'h1a90;
  localparam logic [15:0] RATED_RST    = 16'h0bb8;

  // analog input in millivolts per count, gain in 10 mV steps
  localparam int MV_PER_GAIN = 10;

endpackage : speed_limit_pkg

// >>> core/torque_mode_speed_limiter.sv
/*
 * speed limiter for torque control: picks an effective limit, clips the
 * torque command when measured speed reaches it with torque driving the same way, raises the limit flag.
 * assumes speed and analog samples synchronous to hclk, one control cycle
 * per clock, analog input signed in millivolts, speed signed in rpm/mm/s.
 */
// What this block does
// R1: torque passes the command unchanged; speed only touched by limiting
// R2: limit flag high while speed is held by limit, low otherwise
// R3: limit flag drives an output pin only once allocated to one
// R4: source selection 0 uses internal limit only, applied after restart
// R5: source selection 1 derives external limit from analog input and gain
// R6: with external limiting, effective limit is smaller of external, internal
// R7: cap selection 0 caps internal limit at maximum motor speed, after restart
// R8: cap selection 1 caps internal limit at overspeed detection speed
// R9: rotary motor uses rotary setting, linear motor uses linear setting
// R10: rotary setting 0 to 10000 rpm, default 10000, immediate
// R11: linear setting 0 to 10000 mm/s, default 10000, immediate
// R12: setting above maximum speed replaced by selected cap speed
// R13: external limit uses analog magnitude only, sign ignored
// R14: default gain 6.00 means 6 V gives rated speed, proportional
// R15: gain 150 to 3000 in 0.01 V steps, default 600, immediate
// R16: each cycle compare speed magnitude to limit and cut torque that drives the same way as speed
`timescale 1ns/1ps
module torque_mode_speed_limiter
  import speed_limit_pkg::*;
#(
  parameter int SPD_W = 16,
  parameter int TRQ_W = 16,
  parameter int PIN_N = 3
)(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic signed [15:0] analog_limit_mv,
  input  wire logic signed [SPD_W-1:0] motor_speed,
  input  wire logic signed [TRQ_W-1:0] torque_cmd,
  output logic signed [TRQ_W-1:0] torque_out,
  output logic [PIN_N-1:0]       out_pin,
  output logic                   irq
);

  // register state
  logic [6:0]  cfg_q;
  logic [2:0]  act_sel_q;
  logic [15:0] rot_lim_q;
  logic [15:0] lin_lim_q;
  logic [15:0] gain_q;
  logic [15:0] max_spd_q;
  logic [15:0] ovs_spd_q;
  logic [15:0] rated_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [6:0]  alloc_q;

  // bus address phase capture
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  addr_q;

  // limiter state
  logic                   limiting_q;
  logic signed [TRQ_W-1:0] torque_q;

  wire bus_take = hsel & hready & htrans[1];
  wire wr_cfg   = wr_q & (addr_q == CFG_OFF);
  wire wr_rot   = wr_q & (addr_q == ROT_LIM_OFF);
  wire wr_lin   = wr_q & (addr_q == LIN_LIM_OFF);
  wire wr_gain  = wr_q & (addr_q == GAIN_OFF);
  wire wr_motor = wr_q & (addr_q == MOTOR_OFF);
  wire wr_istat = wr_q & (addr_q == IRQ_STAT_OFF);
  wire wr_imask = wr_q & (addr_q == IRQ_MASK_OFF);
  wire wr_rst   = wr_q & (addr_q == RESTART_OFF) & hwdata[0];

  // clamp settings into their documented ranges
  wire [15:0] wlo = hwdata[15:0];
  wire [15:0] lim_wr = (wlo > INT_LIM_MAX) ? INT_LIM_MAX : wlo; // R10 R11
  wire [15:0] gain_wr = (wlo < GAIN_MIN) ? GAIN_MIN :
                        (wlo > GAIN_MAX) ? GAIN_MAX : wlo;      // R15

  // active selections, refreshed only by restart
  wire src_ext = act_sel_q[SRC_SEL_BIT];  // R4 R5
  wire cap_ovs = act_sel_q[CAP_SEL_BIT];  // R7 R8
  wire linear  = act_sel_q[LINEAR_BIT];   // R9

  // internal limit and its cap
  wire [15:0] int_set = linear ? lin_lim_q : rot_lim_q;         // R9
  wire [15:0] cap_spd = cap_ovs ? ovs_spd_q : max_spd_q;        // R7 R8
  wire [15:0] int_lim = (int_set > cap_spd) ? cap_spd : int_set; // R12

  // external limit: |v| * rated / (gain * 10)  (gain in 10 mV)
  wire [15:0] v_abs = analog_limit_mv[15] ?
                      16'(-analog_limit_mv) : 16'(analog_limit_mv); // R13
  wire [31:0] ext_num = 32'(v_abs) * 32'(rated_q);
  wire [31:0] ext_den = 32'(gain_q) * 32'(MV_PER_GAIN);
  wire [31:0] ext_q32 = ext_num / ext_den;                      // R14
  wire [15:0] ext_lim = (ext_q32 > 32'h0000ffff) ? 16'hffff :
                        ext_q32[15:0];                          // R5
  wire [15:0] eff_lim = (src_ext && ext_lim < int_lim) ?
                        ext_lim : int_lim;                      // R6 R4

  // speed magnitude and torque clipping
  wire [SPD_W-1:0] spd_abs = motor_speed[SPD_W-1] ?
                             SPD_W'(-motor_speed) : SPD_W'(motor_speed);
  wire over   = 32'(spd_abs) >= 32'(eff_lim);                   // R16
  wire drive_same = (torque_cmd[TRQ_W-1] == motor_speed[SPD_W-1]) &&
                    (torque_cmd != '0) && (motor_speed != '0);
  wire limit_now = over & drive_same;                           // R2
  wire signed [TRQ_W-1:0] torque_d = limit_now ? '0 : torque_cmd; // R1 R16

  // interrupt events on limit flag edges
  wire ev_on  = limit_now & ~limiting_q;
  wire ev_off = ~limit_now & limiting_q;
  wire [1:0] ev = {ev_off, ev_on};
  wire [1:0] clr = wr_istat ? hwdata[1:0] : 2'h0;

  // next values of the bus and settings registers
  wire        wr_d       = bus_take & hwrite;
  wire        rd_d       = bus_take & ~hwrite;
  wire [7:0]  addr_d     = haddr[7:0];
  wire [6:0]  cfg_d      = hwdata[6:0];
  wire [2:0]  act_sel_d  = cfg_q[2:0];
  wire [6:0]  alloc_d    = cfg_q;
  wire [15:0] max_spd_d  = hwdata[15:0];
  wire [15:0] ovs_spd_d  = hwdata[31:16];
  wire [1:0]  irq_mask_d = hwdata[1:0];

  // sticky event bits: an event wins over a clear in the same cycle
  logic [1:0] irq_stat_d;
  genvar e;
  generate
    for (e = 0; e < 2; e++)
    begin : g_ev
      assign irq_stat_d[e] = ev[e] | (irq_stat_q[e] & ~clr[e]);
    end
  endgenerate

  // data phase flags and address, taken with the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q <= 8'h00;
    end
    else if (bus_take)
    begin
      addr_q <= addr_d;
    end
  end

  // settings, written at the end of the data phase; rated speed is only loaded by reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q <= 7'h00;
    end
    else if (wr_cfg)
    begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act_sel_q <= 3'h0;
    end
    else if (wr_rst)
    begin
      act_sel_q <= act_sel_d;  // R4 R7
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alloc_q <= 7'h00;
    end
    else if (wr_rst)
    begin
      alloc_q <= alloc_d;  // R3
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rot_lim_q <= INT_LIM_RST;
    end
    else if (wr_rot)
    begin
      rot_lim_q <= lim_wr;  // R10
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lin_lim_q <= INT_LIM_RST;
    end
    else if (wr_lin)
    begin
      lin_lim_q <= lim_wr;  // R11
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gain_q <= GAIN_RST;
    end
    else if (wr_gain)
    begin
      gain_q <= gain_wr;  // R15
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      max_spd_q <= MAX_SPD_RST;
    end
    else if (wr_motor)
    begin
      max_spd_q <= max_spd_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ovs_spd_q <= OVS_SPD_RST;
    end
    else if (wr_motor)
    begin
      ovs_spd_q <= ovs_spd_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rated_q <= RATED_RST;
    end
  end

  // limiter outputs and interrupt state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      limiting_q <= 1'b0;
    end
    else
    begin
      limiting_q <= limit_now;  // R2
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      torque_q <= '0;
    end
    else
    begin
      torque_q <= torque_d;  // R16
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_stat_q <= 2'h0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_mask_q <= 2'h0;
    end
    else if (wr_imask)
    begin
      irq_mask_q <= irq_mask_d;
    end
  end

  // pin allocation: code 0 means unallocated
  wire [2:0] alloc = alloc_q[ALLOC_LSB +: ALLOC_W];
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++)
    begin : g_pin
      assign out_pin[g] = limiting_q &&
                          (alloc == 3'(g + 1));  // R3
    end
  endgenerate

  // read mux
  logic [31:0] rdata_mux;
  always_comb
  begin
    rdata_mux = 32'h0;
    case (addr_q)
      CFG_OFF:      rdata_mux = {25'h0, cfg_q};
      ROT_LIM_OFF:  rdata_mux = {16'h0, rot_lim_q};
      LIN_LIM_OFF:  rdata_mux = {16'h0, lin_lim_q};
      GAIN_OFF:     rdata_mux = {16'h0, gain_q};
      MOTOR_OFF:    rdata_mux = {ovs_spd_q, max_spd_q};
      STATUS_OFF:   rdata_mux = {eff_lim, 12'h0, act_sel_q, limiting_q};
      IRQ_STAT_OFF: rdata_mux = {30'h0, irq_stat_q};
      IRQ_MASK_OFF: rdata_mux = {30'h0, irq_mask_q};
      default:      rdata_mux = 32'h0;
    endcase
  end

  assign hrdata     = rd_q ? rdata_mux : 32'h0;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign torque_out = torque_q;
  assign irq        = |(irq_stat_q & irq_mask_q);

endmodule : torque_mode_speed_limiter

// >>> sim/host_analog_model.sv
/* host controller model: drives the analog limit level in mV.
   assumes the bench sets the wanted level on level_mv. */
`timescale 1ns/1ps
module host_analog_model (
  input  wire logic               hclk,
  input  wire logic signed [15:0] level_mv,
  output logic signed [15:0]      analog_limit_mv
);
  always_ff @(posedge hclk)
    analog_limit_mv <= level_mv;
endmodule : host_analog_model

// >>> sim/torque_mode_speed_limiter_props.sv
/* port checker for the speed limiter.
   assumes it is bound to the limiter top module. */
`timescale 1ns/1ps
module limiter_props #(
  parameter int SPD_W = 16,
  parameter int TRQ_W = 16,
  parameter int PIN_N = 3
)(
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic signed [SPD_W-1:0] motor_speed,
  input wire logic signed [TRQ_W-1:0] torque_cmd,
  input wire logic signed [TRQ_W-1:0] torque_out,
  input wire logic [PIN_N-1:0]        out_pin
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_q;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) rd_q <= 1'b0;
    else rd_q <= hsel & hready & htrans[1] & ~hwrite;
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  chk_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  chk_torque_pass: assert property (
    torque_out == $past(torque_cmd) || torque_out == '0)
    else $error("torque neither passed nor cut");
  chk_flag_cuts: assert property ((|out_pin) |-> torque_out == '0)
    else $error("flag high with torque applied");
  chk_pin_single: assert property ($onehot0(out_pin))
    else $error("flag on more than one pin");
  chk_idle_flag: assert property (
    $past(torque_cmd) == '0 |-> out_pin == '0)
    else $error("flag with no driving torque");
  chk_still_motor: assert property (
    $past(motor_speed) == '0 |-> torque_out == $past(torque_cmd))
    else $error("torque cut at standstill");
  chk_braking_pass: assert property (
    $past(torque_cmd) != '0 && $past(motor_speed) != '0 &&
    $past(torque_cmd[TRQ_W-1]) != $past(motor_speed[SPD_W-1])
    |-> torque_out == $past(torque_cmd))
    else $error("braking torque cut");
endmodule : limiter_props
bind torque_mode_speed_limiter limiter_props #(.SPD_W(SPD_W),
  .TRQ_W(TRQ_W), .PIN_N(PIN_N)) u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .motor_speed(motor_speed), .torque_cmd(torque_cmd),
  .torque_out(torque_out), .out_pin(out_pin));

// >>> sim/test_torque_mode_speed_limiter.sv
/* self-checking bench for the speed limiter.
   assumes a single bus slave, so hready follows hreadyout. */
`timescale 1ns/1ps
module test_torque_mode_speed_limiter;
  import speed_limit_pkg::*;
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic               hwrite = 1'b0;
  logic [31:0]        haddr = '0;
  logic [31:0]        hwdata = '0;
  logic [1:0]         htrans = '0;
  logic [2:0]         hsize = 3'h2;
  logic signed [15:0] lvl = '0;
  logic signed [15:0] spd = '0;
  logic signed [15:0] tc = '0;
  logic [31:0]        hrdata, rd;
  logic               hreadyout, hresp, irq, ok;
  logic signed [15:0] amv, tq;
  logic [2:0]         pin;
  int                 err_total = 0;
  int                 samples_checked = 0;
  always #2.5 hclk = ~hclk;
  host_analog_model u_host (.hclk(hclk), .level_mv(lvl),
    .analog_limit_mv(amv));
  torque_mode_speed_limiter dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .analog_limit_mv(amv), .motor_speed(spd), .torque_cmd(tc),
    .torque_out(tq), .out_pin(pin), .irq(irq));
  task summarize;
    $display("mismatches %0d of %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task wait_rdy;
    int n;
    n = 0;
    do
    begin
      #4 rd = hrdata;
      ok = hreadyout;
      n++;
      @(posedge hclk);
    end while (ok !== 1'b1 && n < 40);
    if (ok !== 1'b1)
    begin
      err_total++;
      summarize;
    end
  endtask : wait_rdy
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask : bus
  task cfg(input logic [31:0] v);
    bus(1'b1, CFG_OFF, v);
    bus(1'b1, RESTART_OFF, 32'h1);
  endtask : cfg
  task run(input logic signed [15:0] s, input logic signed [15:0] t,
           input logic [15:0] et, input logic [2:0] ep);
    @(posedge hclk);
    spd <= s;
    tc <= t;
    repeat (3) @(posedge hclk);
    #1 chk({16'h0, tq}, {16'h0, et});
    chk({29'h0, pin}, {29'h0, ep});
  endtask : run
  task s_regs;
    bus(1'b0, ROT_LIM_OFF, 32'h0);
    chk(rd, 32'h2710);
    bus(1'b0, GAIN_OFF, 32'h0);
    chk(rd, 32'h258);
    bus(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, ROT_LIM_OFF, 32'h3000);
    bus(1'b0, ROT_LIM_OFF, 32'h0);
    chk(rd, 32'h2710);
  endtask : s_regs
  task s_internal;
    cfg(32'h10);
    bus(1'b1, IRQ_MASK_OFF, 32'h1);
    run(5999, 100, 100, 3'h0);
    run(6000, 100, 16'h0, 3'h1);
    chk({31'h0, irq}, 32'h1);
    run(-6000, 100, 100, 3'h0);
    run(-6000, -5, 16'h0, 3'h1);
    run(100, 5, 5, 3'h0);
    bus(1'b1, IRQ_STAT_OFF, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
  endtask : s_internal
  task s_rotary;
    bus(1'b1, ROT_LIM_OFF, 32'd2000);
    run(1999, 50, 50, 3'h0);
    run(2000, 50, 16'h0, 3'h1);
    cfg(32'h14);
    run(2000, 50, 50, 3'h0);
    bus(1'b1, LIN_LIM_OFF, 32'd1500);
    run(1499, 50, 50, 3'h0);
    run(1500, 50, 16'h0, 3'h1);
  endtask : s_rotary
  task s_cap;
    cfg(32'h10);
    bus(1'b1, ROT_LIM_OFF, 32'd10000);
    bus(1'b1, CFG_OFF, 32'h12);
    run(6500, 50, 16'h0, 3'h1);
    bus(1'b1, RESTART_OFF, 32'h1);
    run(6500, 50, 50, 3'h0);
    run(6800, 50, 16'h0, 3'h1);
  endtask : s_cap
  task s_ext;
    @(posedge hclk);
    lvl <= -16'sd4000;
    cfg(32'h31);
    run(1999, 50, 50, 3'h0);
    bus(1'b0, STATUS_OFF, 32'h0);
    chk(rd, 32'h07d00002);
    run(-2000, -50, 16'h0, 3'h4);
    bus(1'b1, GAIN_OFF, 32'h4b0);
    run(999, 50, 50, 3'h0);
    run(1000, 50, 16'h0, 3'h4);
    bus(1'b1, ROT_LIM_OFF, 32'd500);
    run(500, 50, 16'h0, 3'h4);
    bus(1'b1, GAIN_OFF, 32'h258);
    bus(1'b1, ROT_LIM_OFF, 32'd10000);
    @(posedge hclk);
    lvl <= 16'sd6000;
    run(2999, 50, 50, 3'h0);
    run(3000, 50, 16'h0, 3'h4);
  endtask : s_ext
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    s_regs;
    s_internal;
    s_rotary;
    s_cap;
    s_ext;
    summarize;
  end
endmodule : test_torque_mode_speed_limiter
